/* File: hw/dps_control.sv */
// Shift register and longitudinal parity control with an AXI4-Lite port.
// Assumes seq, bufferWord and the address are synchronous to the bit clock.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dps_control
	import dps_pkg::*;
#(
	parameter int unsigned HeaderDelayCycles = DPS_HDR_DELAY_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic recoveredBitClock,
	input wire dps_seq_t seq,
	input wire logic [35:0] bufferWord,
	input wire logic [17:0] desiredDiskAddress,
	output logic serialOut,
	output logic headerMatch,
	output logic bufferClear,
	output logic [35:0] parityWord
);

	////////////////////////////////////////////////////////////////////
	// Register clock side: bus slave state.
	logic awHeld_r, wHeld_r; // Address and data taken, awaiting pair.
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic bValid_r, rValid_r;
	logic [31:0] rData_r;
	logic [1:0] rResp_r, bResp_r;
	dps_ctrl_t ctrl_r; // Mode levels, crossed to the link.
	logic gclrTog_r, snapReqTog_r; // Event toggles toward the link.
	logic [35:0] shiftCopy_r, parityCopy_r; // Snapshot copies.
	logic headerOpen_r; // Header window level.
	logic timerRun_r;
	logic [15:0] timer_r;
	// Synchronisers into the register clock.
	logic secMeta_r, secSync_r, secSeen_r;
	logic hdrMeta_r, hdrSync_r, hdrSeen_r;
	logic ackMeta_r, ackSync_r, ackSeen_r;
	logic matchMeta_r, matchMain_r;
	// Link-side registers that this side samples; declared here first.
	logic sectorTog_r, hdrEndTog_r, snapAckTog_r, headerMatch_r;
	logic [35:0] shiftHold_r, parityHold_r; // Snapshot hold words.

	// Write decode: fires once both halves of a write are held.
	wire writeGo = awHeld_r & wHeld_r & ~bValid_r;
	wire wrCtrl = writeGo & (awAddr_r == DPS_ADDR_CTRL) & wStrb_r[0];
	wire wrHit = (awAddr_r == DPS_ADDR_CTRL) |
		(awAddr_r == DPS_ADDR_STATUS);
	wire readGo = s_axi_arvalid & ~rValid_r;
	wire secEvt = secSync_r ^ secSeen_r;
	wire hdrEvt = hdrSync_r ^ hdrSeen_r;
	wire ackEvt = ackSync_r ^ ackSeen_r;
	wire snapBusy = snapReqTog_r ^ ackSeen_r;
	wire timerDone = timerRun_r &
		(timer_r == 16'(HeaderDelayCycles - 1));
	wire [31:0] statusWord = {29'h0, snapBusy, headerOpen_r, matchMain_r};
	wire [31:0] ctrlWord = {28'h0, ctrl_r.normalMode, ctrl_r.readState,
		ctrl_r.inboundDirection, ctrl_r.maintenanceMode};
	// Read selection; an unmapped address reads zero with an error.
	wire rdHit = (s_axi_araddr == DPS_ADDR_CTRL) |
		(s_axi_araddr == DPS_ADDR_STATUS) |
		(s_axi_araddr == DPS_ADDR_SHIFT_LO) |
		(s_axi_araddr == DPS_ADDR_SHIFT_HI) |
		(s_axi_araddr == DPS_ADDR_PARITY_LO) |
		(s_axi_araddr == DPS_ADDR_PARITY_HI);
	wire [31:0] rdSel =
		(s_axi_araddr == DPS_ADDR_CTRL) ? ctrlWord :
		(s_axi_araddr == DPS_ADDR_STATUS) ? statusWord :
		(s_axi_araddr == DPS_ADDR_SHIFT_LO) ? shiftCopy_r[31:0] :
		(s_axi_araddr == DPS_ADDR_SHIFT_HI) ?
			{28'h0, shiftCopy_r[35:32]} :
		(s_axi_araddr == DPS_ADDR_PARITY_LO) ? parityCopy_r[31:0] :
		(s_axi_araddr == DPS_ADDR_PARITY_HI) ?
			{28'h0, parityCopy_r[35:32]} : 32'h0;

	assign s_axi_awready = ~awHeld_r;
	assign s_axi_wready = ~wHeld_r;
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;
	assign s_axi_arready = ~rValid_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;

	// Write channels are taken independently and answered once both are.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			bValid_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			bResp_r <= DPS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHeld_r) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld_r) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (writeGo) begin
				bValid_r <= 1'b1;
				bResp_r <= wrHit ? DPS_RESP_OKAY : DPS_RESP_SLVERR;
			end else if (bValid_r && s_axi_bready) begin
				bValid_r <= 1'b0;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
			end
		end
	end

	// Read answers one cycle after the address is taken.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rValid_r <= 1'b0;
			rData_r <= 32'h0;
			rResp_r <= DPS_RESP_OKAY;
		end else if (readGo) begin
			rValid_r <= 1'b1;
			rData_r <= rdSel;
			rResp_r <= rdHit ? DPS_RESP_OKAY : DPS_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_r <= 1'b0;
		end
	end

	// Control levels, plus clear and snapshot requests sent as toggles.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl_r <= DPS_CTRL_RESET;
			gclrTog_r <= 1'b0;
			snapReqTog_r <= 1'b0;
		end else if (wrCtrl) begin
			ctrl_r.maintenanceMode <= wData_r[DPS_CTRL_MAINTENANCE_MODE];
			ctrl_r.inboundDirection <= wData_r[DPS_CTRL_INBOUND];
			ctrl_r.readState <= wData_r[DPS_CTRL_READ];
			ctrl_r.normalMode <= wData_r[DPS_CTRL_NORMAL];
			gclrTog_r <= gclrTog_r ^ wData_r[DPS_CTRL_GCLR];
			// A snapshot request while one is pending is ignored.
			snapReqTog_r <= snapReqTog_r ^
				(wData_r[DPS_CTRL_SNAP] & ~snapBusy);
		end
	end

	// Synchronisers from the link; the first stage feeds only the second.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			{secMeta_r, secSync_r, secSeen_r} <= 3'h0;
			{hdrMeta_r, hdrSync_r, hdrSeen_r} <= 3'h0;
			{ackMeta_r, ackSync_r, ackSeen_r} <= 3'h0;
			{matchMeta_r, matchMain_r} <= 2'h0;
		end else begin
			secMeta_r <= sectorTog_r;
			secSync_r <= secMeta_r;
			secSeen_r <= secSync_r;
			hdrMeta_r <= hdrEndTog_r;
			hdrSync_r <= hdrMeta_r;
			hdrSeen_r <= hdrSync_r;
			ackMeta_r <= snapAckTog_r;
			ackSync_r <= ackMeta_r;
			ackSeen_r <= ackSync_r;
			matchMeta_r <= headerMatch_r;
			matchMain_r <= matchMeta_r;
		end
	end

	// Snapshot words are stable in the link hold while the ack travels.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			shiftCopy_r <= 36'h0;
			parityCopy_r <= 36'h0;
		end else if (ackEvt) begin
			shiftCopy_r <= shiftHold_r;
			parityCopy_r <= parityHold_r;
		end
	end

	// Header window opens a fixed delay after a sector pulse in read.
	// The timeout wins over a header end arriving in the same cycle.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			timerRun_r <= 1'b0;
			timer_r <= 16'h0;
			headerOpen_r <= 1'b0;
		end else begin
			if (secEvt && ctrl_r.readState) begin
				timerRun_r <= 1'b1;
				timer_r <= 16'h0;
			end else if (timerDone) begin
				timerRun_r <= 1'b0;
			end else if (timerRun_r) begin
				timer_r <= timer_r + 16'h1;
			end
			if (timerDone) begin
				headerOpen_r <= 1'b1;
			end else if (hdrEvt || secEvt) begin
				headerOpen_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Link side, clocked by the recovered bit clock.
	logic [1:0] linkRst_r; // Reset synchroniser.
	dps_ctrl_t ctrlMeta_r, ctrlLink_r;
	logic gclrMeta_r, gclrSync_r, gclrSeen_r;
	logic snapMeta_r, snapSync_r, snapSeen_r;
	logic openMeta_r, openLink_r;
	logic hdrEndDly_r, firstBitDly_r;
	logic strobeTrail_r, strobeReadTrail_r;
	logic [35:0] shift_r, parity_r;
	logic bufferClear_r;
	logic [35:0] shift_nxt, parity_nxt;

	wire linkResetn = linkRst_r[1];
	wire generalClear = gclrSync_r ^ gclrSeen_r;
	wire snapEvt = snapSync_r ^ snapSeen_r;
	// Edges of drive levels become one-cycle strobes in order.
	wire headerEndTrail = hdrEndDly_r & ~seq.headerEndPulse;
	wire firstBitRise = seq.firstDataBit & ~firstBitDly_r;
	wire parityToShift = seq.lastBitWritten &
		seq.sectorCountOverflow;
	wire bufferEnable = seq.bufferToShift | seq.firstBufferToShift |
		seq.formatBufferToShift;
	// Each link edge is a bit clock pulse, so the gate qualifies it.
	wire loadStrobe = (parityToShift | bufferEnable) &
		seq.dataGate;
	wire shiftStrobe = seq.shiftEnable & seq.shiftPulse;
	wire shiftClock = loadStrobe | shiftStrobe;
	wire dataFieldWrite = (seq.formatGenerator01 &
		seq.formatGenerator02) | seq.lastPostHeaderSync;
	wire writeXorEnable = ~ctrlLink_r.readState & dataFieldWrite &
		seq.wordParityTime & ~seq.sectorCountOverflow;
	wire readWordEnd = ctrlLink_r.readState & seq.endBit;
	wire parityStrobe = (writeXorEnable | readWordEnd) &
		seq.dataGate;
	wire addressStrobe = firstBitRise & openLink_r &
		seq.readGate;
	wire parityClear = seq.sectorPulse | generalClear |
		headerEndTrail;
	// Data field words written in normal mode, before overflow.
	wire writtenWordClear = seq.lastBitWritten &
		ctrlLink_r.normalMode & ~seq.sectorCountOverflow &
		~seq.preHeader;
	wire shiftClear = headerEndTrail | strobeReadTrail_r |
		generalClear | writtenWordClear;
	wire [35:0] loadValue = parityToShift ? ~parity_r :
		bufferWord;
	wire [35:0] shiftValue = {seq.readBit, shift_r[35:1]};
	wire [35:0] addressTerm = addressStrobe ?
		{desiredDiskAddress, 18'h0} : 36'h0;
	wire [35:0] shiftTerm = parityStrobe ? shift_r : 36'h0;
	// Overflow is taken with the strobe itself, since the drive may drop
	// it before the trailing edge is acted on one cycle later.
	wire bufferClearQual = seq.wordCountOverflow |
		ctrlLink_r.inboundDirection;
	wire bufferClearNow = ctrlLink_r.maintenanceMode ?
		(loadStrobe & bufferClearQual) : strobeTrail_r;

	// Clear beats load, load beats shift.
	always_comb begin
		shift_nxt = shift_r;
		if (shiftClear) begin
			shift_nxt = 36'h0;
		end else if (shiftClock) begin
			shift_nxt = loadStrobe ? loadValue : shiftValue;
		end
	end

	// Parity only ever XORs; a load is a clear followed by an XOR.
	always_comb begin
		parity_nxt = parity_r ^ shiftTerm ^ addressTerm;
		if (parityClear) begin
			parity_nxt = 36'h0;
		end
	end

	assign serialOut = shift_r[0];
	assign parityWord = parity_r;
	assign headerMatch = headerMatch_r;
	assign bufferClear = bufferClear_r;

	// Reset release reaches the link through two stages.
	always_ff @(posedge recoveredBitClock) begin
		linkRst_r <= {linkRst_r[0], resetn};
	end

	// Synchronisers from the register clock into the link.
	always_ff @(posedge recoveredBitClock) begin
		if (!linkResetn) begin
			ctrlMeta_r <= DPS_CTRL_RESET;
			ctrlLink_r <= DPS_CTRL_RESET;
			{gclrMeta_r, gclrSync_r, gclrSeen_r} <= 3'h0;
			{snapMeta_r, snapSync_r, snapSeen_r} <= 3'h0;
			{openMeta_r, openLink_r} <= 2'h0;
		end else begin
			ctrlMeta_r <= ctrl_r;
			ctrlLink_r <= ctrlMeta_r;
			gclrMeta_r <= gclrTog_r;
			gclrSync_r <= gclrMeta_r;
			gclrSeen_r <= gclrSync_r;
			snapMeta_r <= snapReqTog_r;
			snapSync_r <= snapMeta_r;
			snapSeen_r <= snapSync_r;
			openMeta_r <= headerOpen_r;
			openLink_r <= openMeta_r;
		end
	end

	// Data path registers and edge history.
	always_ff @(posedge recoveredBitClock) begin
		if (!linkResetn) begin
			shift_r <= 36'h0;
			parity_r <= 36'h0;
			hdrEndDly_r <= 1'b0;
			firstBitDly_r <= 1'b0;
			strobeTrail_r <= 1'b0;
			strobeReadTrail_r <= 1'b0;
			headerMatch_r <= 1'b0;
			bufferClear_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			parity_r <= parity_nxt;
			hdrEndDly_r <= seq.headerEndPulse;
			firstBitDly_r <= seq.firstDataBit;
			// Trailing edge of the second-half strobe, one cycle on.
			strobeTrail_r <= parityStrobe & bufferClearQual;
			strobeReadTrail_r <= parityStrobe & seq.readGate;
			headerMatch_r <= (parity_nxt[35:18] == 18'h0);
			bufferClear_r <= bufferClearNow;
		end
	end

	// Events toward the register clock and the snapshot hold.
	always_ff @(posedge recoveredBitClock) begin
		if (!linkResetn) begin
			sectorTog_r <= 1'b0;
			hdrEndTog_r <= 1'b0;
			snapAckTog_r <= 1'b0;
			shiftHold_r <= 36'h0;
			parityHold_r <= 36'h0;
		end else begin
			sectorTog_r <= sectorTog_r ^ seq.sectorPulse;
			hdrEndTog_r <= hdrEndTog_r ^ headerEndTrail;
			if (snapEvt) begin
				shiftHold_r <= shift_r;
				parityHold_r <= parity_r;
				snapAckTog_r <= ~snapAckTog_r;
			end
		end
	end

endmodule : dps_control

/* File: hw/dps_pkg.sv */
// Constants and carrier types for the disk parity and shift control.
// Assumes a 20 MHz register clock and a link clocked by the bit clock.
package dps_pkg;
	// Word and half-word widths of the shift and parity registers.
	localparam int unsigned DPS_WORD_W = 36;
	localparam int unsigned DPS_HALF_W = 18;
	// Register clock period and the header window delay.
	localparam int unsigned DPS_CLK_PERIOD_NS = 50;
	localparam int unsigned DPS_HDR_DELAY_US = 350;
	localparam int unsigned DPS_HDR_DELAY_CYC =
		(DPS_HDR_DELAY_US * 1000) / DPS_CLK_PERIOD_NS;
	// Byte offsets of the registers.
	localparam logic [7:0] DPS_ADDR_CTRL = 8'h00;
	localparam logic [7:0] DPS_ADDR_STATUS = 8'h04;
	localparam logic [7:0] DPS_ADDR_SHIFT_LO = 8'h08;
	localparam logic [7:0] DPS_ADDR_SHIFT_HI = 8'h0c;
	localparam logic [7:0] DPS_ADDR_PARITY_LO = 8'h10;
	localparam logic [7:0] DPS_ADDR_PARITY_HI = 8'h14;
	// Field positions in the control register.
	localparam int unsigned DPS_CTRL_MAINTENANCE_MODE = 0;
	localparam int unsigned DPS_CTRL_INBOUND = 1;
	localparam int unsigned DPS_CTRL_READ = 2;
	localparam int unsigned DPS_CTRL_NORMAL = 3;
	localparam int unsigned DPS_CTRL_GCLR = 4;
	localparam int unsigned DPS_CTRL_SNAP = 5;
	// Field positions in the status register.
	localparam int unsigned DPS_STAT_MATCH = 0;
	localparam int unsigned DPS_STAT_OPEN = 1;
	localparam int unsigned DPS_STAT_BUSY = 2;
	// Bus responses.
	localparam logic [1:0] DPS_RESP_OKAY = 2'h0;
	localparam logic [1:0] DPS_RESP_SLVERR = 2'h2;
	// Mode levels written by software.
	typedef struct packed {
		logic maintenanceMode;
		logic inboundDirection;
		logic readState;
		logic normalMode;
	} dps_ctrl_t;
	// Control state after reset.
	localparam dps_ctrl_t DPS_CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};
	// Sequencer and drive signals, all on the bit clock.
	typedef struct packed {
		logic dataGate;
		logic readGate;
		logic readBit;
		logic shiftEnable;
		logic shiftPulse;
		logic bufferToShift;
		logic firstBufferToShift;
		logic formatBufferToShift;
		logic lastBitWritten;
		logic sectorCountOverflow;
		logic wordCountOverflow;
		logic sectorPulse;
		logic wordParityTime;
		logic formatGenerator01;
		logic formatGenerator02;
		logic lastPostHeaderSync;
		logic preHeader;
		logic endBit;
		logic firstDataBit;
		logic headerEndPulse;
	} dps_seq_t;
endpackage : dps_pkg

/* File: bench/dps_control_props.sv */
// Checker for the parity and shift control outputs on the bit clock.
// Assumes a bind into dps_control; seq is sampled on the bit clock.
`timescale 1ns/1ps
module dps_control_props
	import dps_pkg::*;
#(
	parameter int unsigned HeaderDelayCycles = DPS_HDR_DELAY_CYC
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic recoveredBitClock,
	input wire dps_seq_t seq,
	input wire logic [35:0] bufferWord,
	input wire logic serialOut,
	input wire logic headerMatch,
	input wire logic bufferClear,
	input wire logic [35:0] parityWord
);
	default clocking cb @(posedge recoveredBitClock);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////
	// Level history, since edge-made clears land a cycle late.
	logic [1:0] heHist;
	logic rgPrev;
	logic fdPrev;
	always_ff @(posedge recoveredBitClock) begin
		heHist <= {heHist[0], seq.headerEndPulse};
		rgPrev <= seq.readGate;
		fdPrev <= seq.firstDataBit;
	end
	// No header-end or read-word clear of the shift register can land at this edge.
	wire logic quiet = !seq.readGate && !rgPrev &&
		!seq.headerEndPulse && heHist == 2'h0;
	wire logic anyBuf = seq.bufferToShift || seq.firstBufferToShift ||
		seq.formatBufferToShift;
	wire logic fdRise = seq.firstDataBit && !fdPrev;
	wire logic noPar = !seq.dataGate && !seq.sectorPulse &&
		!seq.headerEndPulse && heHist == 2'h0;
	////////////////////////////////////////////////////////////
	chk_parity_load:
	assert property (seq.lastBitWritten && seq.sectorCountOverflow &&
		seq.dataGate && !anyBuf && quiet |=>
		serialOut == !$past(parityWord[0]))
		else $error("parity word not loaded inverted");
	chk_buffer_load:
	assert property (seq.dataGate && anyBuf && !seq.lastBitWritten &&
		quiet |=> serialOut == $past(bufferWord[0]))
		else $error("buffer word not loaded");
	chk_gate_hold:
	assert property (!seq.dataGate && !(seq.shiftEnable &&
		seq.shiftPulse) && quiet |=> $stable(serialOut) || !serialOut)
		else $error("shift register moved without strobe");
	chk_parity_xor_only:
	assert property (noPar && !fdRise |=>
		$stable(parityWord) || parityWord == 36'h0)
		else $error("parity changed without strobe");
	chk_low_half:
	assert property (noPar && fdRise |=> $stable(parityWord[17:0]))
		else $error("address touched first half");
	chk_sector_clear:
	assert property (seq.sectorPulse |=> parityWord == 36'h0)
		else $error("sector pulse left parity");
	chk_match_flag:
	assert property (!$stable(parityWord) |->
		headerMatch == (parityWord[35:18] == 18'h0))
		else $error("header match wrong");
	chk_bclr_cause:
	assert property (bufferClear |-> $past(seq.dataGate) ||
		$past(seq.dataGate, 2) || $past(seq.dataGate, 3))
		else $error("buffer clear without strobe");
	cover property ($rose(headerMatch));
	cover property (bufferClear);
	cover property (fdRise && seq.readGate);
endmodule : dps_control_props
bind dps_control dps_control_props #(
	.HeaderDelayCycles(HeaderDelayCycles)
) u_props (
	.clock(clock), .resetn(resetn), .seq(seq),
	.recoveredBitClock(recoveredBitClock), .bufferWord(bufferWord),
	.serialOut(serialOut), .headerMatch(headerMatch),
	.bufferClear(bufferClear), .parityWord(parityWord)
);

/* File: bench/dps_drive_model.sv */
// Drive read channel model: makes the bit clock and sequencer levels.
// Assumes the bench calls step once for each bit cell.
`timescale 1ns/1ps
module dps_drive_model
	import dps_pkg::*;
(
	output logic recoveredBitClock,
	output dps_seq_t seq
);
	// A 160 ns bit cell, started off the register clock phase.
	initial begin
		recoveredBitClock = 1'b0;
		seq = '0;
		#37;
		forever #80 recoveredBitClock = !recoveredBitClock;
	end
	// Levels change just after an edge; a strobe lasts one cell.
	task automatic step(input dps_seq_t v);
		@(posedge recoveredBitClock);
		seq <= v;
	endtask : step
endmodule : dps_drive_model

/* File: bench/dps_control_tb.sv */
// Self-checking bench for the parity and shift control.
// Assumes the drive model owns the bit clock and sequencer levels.
`timescale 1ns/1ps
module dps_control_tb;
	import dps_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] awAddr = 8'h00;
	logic [7:0] arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic awValid = 1'b0;
	logic wValid = 1'b0;
	logic bReady = 1'b0;
	logic arValid = 1'b0;
	logic rReady = 1'b0;
	logic [35:0] bufWord = 36'h0;
	logic [17:0] dAddr = 18'h0;
	logic awReady, wReady, bValid, arReady, rValid, lclk, sOut, hMatch, bClr;
	logic [1:0] bResp, rResp, rr, wr;
	logic [31:0] rData, ctrlV, rd;
	logic [35:0] parWord, snapS, w, w2, hdr;
	dps_seq_t seq, v;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	always #25 clock = !clock;
	dps_control #(.HeaderDelayCycles(20)) dut (
		.clock(clock), .resetn(resetn), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .recoveredBitClock(lclk), .seq(seq),
		.bufferWord(bufWord), .desiredDiskAddress(dAddr),
		.serialOut(sOut), .headerMatch(hMatch), .bufferClear(bClr),
		.parityWord(parWord)
	);
	dps_drive_model drv (.recoveredBitClock(lclk), .seq(seq));
	////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// A hang is cut short well above the expected run length.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end
	task automatic chkw(input logic [35:0] g, e, input string m);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chkw
	// Each channel is released at the edge that takes it.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge clock);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
		end while (!bValid);
		wr = bResp;
		bReady <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clock);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge clock);
			if (arReady) arValid <= 1'b0;
		end while (!rValid);
		d = rData;
		r = rResp;
		rReady <= 1'b0;
	endtask : axr
	// Mode levels need a few bit cells to cross.
	task automatic setc(input logic [31:0] c);
		ctrlV = c;
		axw(DPS_ADDR_CTRL, c);
		repeat (3) @(posedge lclk);
	endtask : setc
	task automatic snap;
		logic [31:0] lo;
		axw(DPS_ADDR_CTRL, ctrlV | 32'h20);
		do axr(DPS_ADDR_STATUS, lo, rr); while (lo[DPS_STAT_BUSY]);
		axr(DPS_ADDR_SHIFT_LO, lo, rr);
		axr(DPS_ADDR_SHIFT_HI, rd, rr);
		snapS = {rd[3:0], lo};
	endtask : snap
	task automatic hold(input dps_seq_t x, input int k);
		repeat (k) drv.step(x);
	endtask : hold
	task automatic load(input logic [35:0] x);
		bufWord <= x;
		drv.step('{dataGate:1'b1, bufferToShift:1'b1, default:1'b0});
	endtask : load
	// Bit zero leaves first; one bit cell per shift strobe.
	task automatic shout(input logic [35:0] x);
		for (int i = 0; i < 36; i++) begin
			drv.step('{shiftEnable:1'b1, shiftPulse:1'b1, default:1'b0});
			#1 chkw(36'(sOut), 36'(x[i]), "serial bit");
		end
	endtask : shout
	////////////////////////////////////////////////////////////
	initial begin
		ctrlV = 32'h0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		hold('0, 6);
		chkw(parWord, 36'h0, "parity at reset");
		axr(8'h3c, rd, rr);
		chkw(36'({rr, rd}), 36'({DPS_RESP_SLVERR, 32'h0}), "unmapped");
		axw(8'h3c, 32'h0);
		chkw(36'(wr), 36'(DPS_RESP_SLVERR), "unmapped write");
		$display("test reset done");
		bufWord <= 36'h9a5c30f1d;
		drv.step('{bufferToShift:1'b1, default:1'b0});
		hold('0, 1);
		#1 chkw(36'(sOut), 36'h0, "load without gate");
		w = 36'h9a5c30f1d;
		for (int k = 0; k < 3; k++) begin
			v = '{dataGate:1'b1, default:1'b0};
			v.bufferToShift = (k == 0);
			v.firstBufferToShift = (k == 1);
			v.formatBufferToShift = (k == 2);
			bufWord <= w;
			drv.step(v);
			shout(w);
			w = {w[34:0], w[35]};
		end
		$display("test load and shift done");
		w2 = 36'h53c96a18e;
		v = '{dataGate:1'b1, wordParityTime:1'b1, default:1'b0};
		load(w);
		v.formatGenerator01 = 1'b1;
		v.formatGenerator02 = 1'b1;
		drv.step(v);
		load(w2);
		drv.step('{dataGate:1'b1, wordParityTime:1'b1,
			lastPostHeaderSync:1'b1, default:1'b0});
		v.formatGenerator02 = 1'b0;
		drv.step(v);
		v.formatGenerator02 = 1'b1;
		v.sectorCountOverflow = 1'b1;
		drv.step(v);
		hold('0, 2);
		#1 chkw(parWord, w ^ w2, "write parity");
		drv.step('{dataGate:1'b1, lastBitWritten:1'b1,
			sectorCountOverflow:1'b1, default:1'b0});
		shout(~(w ^ w2));
		setc(32'h8);
		chkw(36'(wr), 36'(DPS_RESP_OKAY), "control write");
		load(w);
		drv.step('{dataGate:1'b1, lastBitWritten:1'b1, default:1'b0});
		hold('0, 3);
		snap();
		chkw(snapS, 36'h0, "written word clear");
		$display("test write parity done");
		for (int k = 0; k < 4; k++) begin
			setc({30'h0, k == 3, k == 1});
			v = '{dataGate:1'b1, default:1'b0};
			v.wordCountOverflow = (k < 2);
			v.bufferToShift = (k == 1);
			v.formatGenerator01 = (k != 1);
			v.formatGenerator02 = (k != 1);
			v.wordParityTime = (k != 1);
			drv.step(v);
			n = 0;
			repeat (4) begin
				drv.step('0);
				#1 n += int'(bClr);
			end
			chkw(36'(n), 36'(k != 2), "buffer clear count");
		end
		$display("test buffer clear done");
		setc(32'h4);
		for (int p = 0; p < 2; p++) begin
			dAddr <= 18'h2d1b3;
			hdr = {18'h2d1b3 ^ 18'(p), 18'h30c5a};
			drv.step('{readGate:1'b1, sectorPulse:1'b1, default:1'b0});
			hold('{readGate:1'b1, default:1'b0}, 1);
			#1 chkw(parWord, 36'h0, "sector clear");
			do axr(DPS_ADDR_STATUS, rd, rr); while (!rd[DPS_STAT_OPEN]);
			// The open level takes two bit cells to reach the link side.
			hold('{readGate:1'b1, default:1'b0}, 2);
			v = '{readGate:1'b1, firstDataBit:1'b1, default:1'b0};
			hold(v, 2);
			#1 chkw(parWord, {dAddr, 18'h0}, "address xor");
			v.shiftEnable = 1'b1;
			v.shiftPulse = 1'b1;
			for (int i = 0; i < 36; i++) begin
				v.readBit = hdr[i];
				drv.step(v);
			end
			v = '{readGate:1'b1, firstDataBit:1'b1, default:1'b0};
			drv.step('{readGate:1'b1, firstDataBit:1'b1, endBit:1'b1,
				dataGate:1'b1, default:1'b0});
			hold(v, 2);
			#1 chkw(parWord, hdr ^ {dAddr, 18'h0}, "header xor");
			chkw(36'(hMatch), 36'(p == 0), "header match");
			snap();
			chkw(snapS, 36'h0, "read word clear");
			if (p == 0) begin
				drv.step('{readGate:1'b1, headerEndPulse:1'b1, default:1'b0});
				hold('0, 3);
			end else begin
				// The clear bit is a pulse, so it stays out of ctrlV.
				axw(DPS_ADDR_CTRL, ctrlV | 32'h10);
				repeat (3) @(posedge lclk);
			end
			#1 chkw(parWord, 36'h0, "parity clear");
		end
		$display("test header compare done");
		wrap_up();
	end
endmodule : dps_control_tb
